// ==== pkg/mmdec_pkg.sv ====
// constants for the memory map decoder
package mmdec_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam logic [19:0] FLASH_BASE   = 20'h00000;
  localparam logic [19:0] FLASH_LAST   = 20'h1FFFF;
  localparam int          FLASH_BYTES  = 131072;
  localparam logic [19:0] VEC_LAST     = 20'h0007F;
  localparam logic [19:0] VEC_BRK      = 20'h0007E;
  localparam logic [19:0] SHORT_TABLE_CALL_BASE   = 20'h00080;
  localparam logic [19:0] SHORT_TABLE_CALL_LAST   = 20'h000BF;
  localparam logic [19:0] OPT_BASE     = 20'h000C0;
  localparam logic [19:0] OPT_LAST     = 20'h000C3;
  localparam logic [19:0] SECID_BASE   = 20'h000C4;
  localparam logic [19:0] SECID_LAST   = 20'h000CD;
  localparam logic [19:0] SWAP_OFFSET  = 20'h01000;
  localparam logic [19:0] LOW64K_LAST  = 20'h0FFFF;
  localparam logic [19:0] MIRROR_BASE  = 20'hF0000;
  localparam logic [19:0] EXT_LAST     = 20'hF07FF;
  localparam logic [19:0] RAM_BASE     = 20'hFE300;
  localparam logic [19:0] RAM_LAST     = 20'hFFEFF;
  localparam int          RAM_BYTES    = 7168;
  localparam logic [19:0] GPR_BASE     = 20'hFFEE0;
  localparam logic [19:0] SFR_BASE     = 20'hFFF00;
  localparam logic [19:0] MSC_ADDR     = 20'hFFFFE;
  localparam logic [7:0]  MSC_RESET    = 8'h00;
  localparam int          MSC_SEL_BIT  = 0;
  localparam logic [7:0]  UNDEF_DATA   = 8'hFF;
  typedef enum logic [3:0] {
    MMDEC_NONE   = 4'b0000,
    MMDEC_FLASH  = 4'b0001,
    MMDEC_MIRROR = 4'b0010,
    MMDEC_RAM    = 4'b0011,
    MMDEC_GPR    = 4'b0100,
    MMDEC_SFR    = 4'b0101,
    MMDEC_EXT    = 4'b0110,
    MMDEC_MSC    = 4'b0111
  } mmdec_region_e;
  typedef enum logic [2:0] {
    MMDEC_FA_CODE  = 3'b000,
    MMDEC_FA_VEC   = 3'b001,
    MMDEC_FA_SHORT_TABLE_CALL = 3'b010,
    MMDEC_FA_OPT   = 3'b011,
    MMDEC_FA_SECID = 3'b100
  } mmdec_farea_e;
endpackage : mmdec_pkg

// ==== tb/mmdec_flash_model.sv ====
// behavioural code flash answering the decoder read strobe
`timescale 1ns/100ps
module mmdec_flash_model (
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic [16:0] addr,
  output logic      [7:0]  rdata
);
  function automatic logic [7:0] pattern(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {7'h00, a[16]} ^ 8'h5A;
  endfunction : pattern
  initial rdata = 8'hA5;
  // toggles outside reads so stale data never passes as a match
  always @(posedge clk) begin
    if (rd) begin
      rdata <= pattern(addr);
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : mmdec_flash_model

// ==== tb/tb_mmdec_top.sv ====
// bench for the memory map decoder
`timescale 1ns/100ps
module tb_mmdec_top;
  import mmdec_pkg::*;
  logic        clock, reset, req, fetch, write, bit_op, boot_swap;
  logic        frd, ssel, esel, err, vld, msel, s_frd, s_ssel, s_esel;
  logic [2:0]  bit_sel, area, s_area;
  logic [3:0]  region;
  logic [7:0]  wdata, frdata, rdata;
  logic [16:0] faddr, s_fa;
  logic [19:0] addr;
  int          fail_count, n_checks;
  logic [19:0] ta [16] = '{20'h00000, 20'h00001, 20'h0007E, 20'h0007F, 20'h00080,
    20'h000BF, 20'h000C0, 20'h000C3, 20'h000C4, 20'h000CD, 20'h000CE, 20'h1FFFF,
    20'h01000, 20'h01080, 20'h010C0, 20'h010CD};
  logic [2:0]  te [16] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4,
    3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [19:0] ma [9] = '{20'hF1234, 20'hF0800, 20'hFE2FF, 20'hF07FF, 20'hF0000,
    20'hFFF00, 20'hFFFFF, 20'h20000, 20'hEFFFF};
  logic [3:0]  mr [9] = '{4'h2, 4'h2, 4'h2, 4'h6, 4'h6, 4'h5, 4'h5, 4'h0, 4'h0};

  mmdec_top i_dut (.CLOCK(clock), .RESET(reset), .REQ(req), .FETCH(fetch), .WRITE(write),
    .BIT_OP(bit_op), .BIT_SEL(bit_sel), .ADDR(addr), .WDATA(wdata), .BOOT_SWAP(boot_swap),
    .FLASH_RDATA(frdata), .FLASH_ADDR(faddr), .FLASH_RD(frd), .SFR_SEL(ssel),
    .EXT_SEL(esel), .ACC_ERROR(err), .REGION(region), .FLASH_AREA(area), .VALID(vld),
    .RDATA(rdata), .MIRROR_SELECT(msel));
  mmdec_flash_model i_flash (.clk(clock), .rd(frd), .addr(faddr), .rdata(frdata));

  function automatic logic [7:0] fd(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {7'h00, a[16]} ^ 8'h5A;
  endfunction : fd

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // one request: comb outputs caught in c0, flags in c1, data in c2
  task automatic acc(input logic f, w, b, input logic [2:0] bs, input logic [19:0] a,
    input logic [7:0] d, input logic e, input logic [3:0] rg, input logic [7:0] q);
    @(negedge clock);
    req = 1'h1;
    fetch = f;
    write = w;
    bit_op = b;
    bit_sel = bs;
    addr = a;
    wdata = d;
    #1;
    {s_fa, s_frd, s_ssel, s_esel, s_area} = {faddr, frd, ssel, esel, area};
    @(negedge clock);
    req = 1'h0;
    chk("ACC_ERROR", e, err);
    chk("REGION", rg, region);
    chk("VALID", 1'h0, vld);
    @(negedge clock);
    chk("RDATA", q, rdata);
    if (!w && !e) begin
      chk("VALID", 1'h1, vld);
    end
  endtask : acc

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // hang guard
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  initial begin
    {req, fetch, write, bit_op, boot_swap, bit_sel, addr, wdata} = '0;
    reset = 1'h1;
    repeat (20) @(negedge clock);
    chk("MIRROR_SELECT", 1'h0, msel);
    chk("RDATA", UNDEF_DATA, rdata);
    reset = 1'h0;
    acc('0, '0, '0, '0, MSC_ADDR, '0, '0, MMDEC_MSC, MSC_RESET);
    for (int i = 0; i < 16; i++) begin
      boot_swap = (i > 11);
      acc('0, '0, '0, '0, ta[i], '0, '0, MMDEC_FLASH, fd(ta[i]));
      chk("FLASH_AREA", te[i], s_area);
      chk("FLASH_ADDR", ta[i], s_fa);
      chk("FLASH_RD", 1'h1, s_frd);
    end
    boot_swap = '0;
    for (int i = 0; i < 9; i++) begin
      acc('0, '0, '0, '0, ma[i], '0, mr[i] == MMDEC_NONE, mr[i],
        mr[i] == MMDEC_MIRROR ? fd({4'h0, ma[i][15:0]}) : UNDEF_DATA);
      chk("SFR_SEL", mr[i] == MMDEC_SFR, s_ssel);
      chk("FLASH_RD", mr[i] == MMDEC_MIRROR, s_frd);
      chk("EXT_SEL", mr[i] == MMDEC_EXT, s_esel);
      if (mr[i] == MMDEC_MIRROR) begin
        chk("FLASH_ADDR", {4'h0, ma[i][15:0]}, s_fa);
      end
    end
    acc('0, '1, '0, '0, RAM_BASE, 8'h3C, '0, MMDEC_RAM, UNDEF_DATA);
    acc('0, '1, '0, '0, 20'hFFEDF, 8'hC3, '0, MMDEC_RAM, UNDEF_DATA);
    acc('0, '1, '0, '0, GPR_BASE, 8'h69, '0, MMDEC_GPR, UNDEF_DATA);
    acc('0, '0, '0, '0, 20'hFFEDF, '0, '0, MMDEC_RAM, 8'hC3);
    acc('0, '0, '0, '0, GPR_BASE, '0, '0, MMDEC_GPR, 8'h69);
    acc('1, '0, '0, '0, RAM_BASE, '0, '0, MMDEC_RAM, 8'h3C);
    acc('1, '0, '0, '0, GPR_BASE, '0, '1, MMDEC_GPR, UNDEF_DATA);
    acc('1, '0, '0, '0, 20'hF1234, '0, '1, MMDEC_MIRROR, UNDEF_DATA);
    acc('0, '1, '0, '0, 20'hF1234, 8'h00, '1, MMDEC_MIRROR, UNDEF_DATA);
    acc('0, '1, '0, '0, 20'h00100, 8'h00, '0, MMDEC_FLASH, UNDEF_DATA);
    acc('0, '0, '0, '0, 20'h00100, '0, '0, MMDEC_FLASH, fd(20'h00100));
    acc('0, '0, '0, '0, 20'hF1234, '0, '0, MMDEC_MIRROR, fd(20'h01234));
    acc('0, '1, '0, '0, MSC_ADDR, 8'hFF, '0, MMDEC_MSC, UNDEF_DATA);
    chk("MIRROR_SELECT", 1'h1, msel);
    acc('0, '0, '0, '0, MSC_ADDR, '0, '0, MMDEC_MSC, 8'h01);
    acc('0, '1, '1, 3'h3, MSC_ADDR, 8'h00, '0, MMDEC_MSC, UNDEF_DATA);
    chk("MIRROR_SELECT", 1'h1, msel);
    acc('0, '1, '1, 3'h0, MSC_ADDR, 8'h00, '0, MMDEC_MSC, UNDEF_DATA);
    chk("MIRROR_SELECT", 1'h0, msel);
    acc('0, '1, '1, 3'h0, MSC_ADDR, 8'h01, '0, MMDEC_MSC, UNDEF_DATA);
    chk("MIRROR_SELECT", 1'h1, msel);
    acc('0, '0, '0, '0, 20'hF1234, '0, '0, MMDEC_MIRROR, fd(20'h01234));
    reset = 1'h1;
    repeat (2) @(negedge clock);
    reset = 1'h0;
    chk("MIRROR_SELECT", 1'h0, msel);
    // byte write then read of the control register on the next cycle
    @(negedge clock);
    {req, write, bit_op, addr, wdata} = {1'h1, 1'h1, 1'h0, MSC_ADDR, 8'h01};
    @(negedge clock);
    write = 1'h0;
    @(negedge clock);
    req = 1'h0;
    @(negedge clock);
    chk("RDATA", 8'h01, rdata);
    chk("MIRROR_SELECT", 1'h1, msel);
    stop_test();
  end
endmodule : tb_mmdec_top

// ==== verilog/mmdec_ram.sv ====
// byte-wide single-port memory with registered read data
`timescale 1ns/100ps
module mmdec_ram #(
  parameter int DEPTH = 7168,
  parameter int AW    = 13
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : mmdec_ram

// ==== verilog/mmdec_top.sv ====
// memory map decoder: region select, mirror, ram and mirror control register
// Overview of operation
// RL1 - code flash is 128 KB at 00000H to 1FFFFH
// RL2 - first 128 flash bytes hold reset and interrupt start addresses
// RL3 - vector entries are two bytes, targets inside the low 64 KB
// RL4 - vector low byte at even address, high byte at following odd
// RL5 - every reset cause uses entry 00000H; break uses 0007EH
// RL6 - boot swap software puts a second vector table at 01000H
// RL7 - 00080H to 000BFH hold short table call entries
// RL8 - boot swap software copies table call entries to 01080H
// RL9 - option bytes at 000C0H to 000C3H, swap copy at 010C0H
// RL10 - software stores ten byte debug id at 000C4H, copy at 010C4H
// RL11 - reads of F0000H to FFFFFH return flash 00000H to 0FFFFH
// RL12 - registers, ram and prohibited areas override the mirror
// RL13 - mirror is read only; writes ignored, fetches unsupported
// RL14 - mirror control at FFFFEH, bit or byte writes, resets to 00H
// RL15 - software keeps select bit zero; upper bits read zero
// RL16 - software waits one instruction after writing mirror control
// RL17 - 7168 byte ram at FE300H to FFEFFH for data, stack, fetch
// RL18 - top 32 ram bytes are register banks; no fetch there
// RL19 - peripheral registers decoded from FFF00H upward
// RL20 - extended peripheral registers decoded at F0000H to F07FFH
// RL21 - software avoids unassigned peripheral register addresses
// RL22 - one region per address; undefined reads have no side effect
`timescale 1ns/100ps
module mmdec_top
  import mmdec_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        REQ,
  input  wire logic        FETCH,
  input  wire logic        WRITE,
  input  wire logic        BIT_OP,
  input  wire logic [2:0]  BIT_SEL,
  input  wire logic [19:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        BOOT_SWAP,
  input  wire logic [7:0]  FLASH_RDATA,
  output logic      [16:0] FLASH_ADDR,
  output logic             FLASH_RD,
  output logic             SFR_SEL,
  output logic             EXT_SEL,
  output logic             ACC_ERROR,
  output logic      [3:0]  REGION,
  output logic      [2:0]  FLASH_AREA,
  output logic             VALID,
  output logic      [7:0]  RDATA,
  output logic             MIRROR_SELECT
);

  typedef struct packed {
    logic [7:0]    msc;
    logic          pend;
    logic          valid;
    mmdec_region_e reg_q;
    logic          bad;
    logic [7:0]    rdat;
  } mmdec_state_s;

  mmdec_state_s state;
  mmdec_state_s next_state;
  mmdec_region_e region;
  mmdec_farea_e  farea;
  logic [19:0]   phys;
  logic          prohibited;
  logic          ram_we;
  logic [12:0]   ram_addr;
  logic [7:0]    ram_rdata;

  function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // swap copies share the same layout one 4 KB up
  function automatic mmdec_farea_e flash_area(input logic [19:0] a);
    if (a <= VEC_LAST) begin
      flash_area = MMDEC_FA_VEC; // [RL2] [RL5]
    end else if (in_range(a, SHORT_TABLE_CALL_BASE, SHORT_TABLE_CALL_LAST)) begin
      flash_area = MMDEC_FA_SHORT_TABLE_CALL; // [RL7]
    end else if (in_range(a, OPT_BASE, OPT_LAST)) begin
      flash_area = MMDEC_FA_OPT; // [RL9]
    end else if (in_range(a, SECID_BASE, SECID_LAST)) begin
      flash_area = MMDEC_FA_SECID;
    end else begin
      flash_area = MMDEC_FA_CODE;
    end
  endfunction : flash_area

  // priority order makes each address land in one region
  always_comb begin
    region     = MMDEC_NONE; // [RL22]
    prohibited = 1'b0;
    phys       = ADDR;
    if (ADDR <= FLASH_LAST) begin
      region = MMDEC_FLASH; // [RL1]
    end else if (ADDR == MSC_ADDR) begin
      region = MMDEC_MSC; // [RL14]
    end else if (ADDR >= SFR_BASE) begin
      region = MMDEC_SFR; // [RL19] [RL12]
    end else if (ADDR >= GPR_BASE) begin
      region     = MMDEC_GPR; // [RL18]
      prohibited = FETCH;
    end else if (ADDR >= RAM_BASE) begin
      region = MMDEC_RAM; // [RL17] [RL12]
    end else if (ADDR <= EXT_LAST && ADDR >= MIRROR_BASE) begin
      region = MMDEC_EXT; // [RL20] [RL12]
    end else if (ADDR >= MIRROR_BASE) begin
      region     = MMDEC_MIRROR; // [RL11]
      phys       = ADDR & LOW64K_LAST;
      prohibited = FETCH || WRITE; // [RL13]
    end
    if (region == MMDEC_NONE) begin
      prohibited = 1'b1;
    end
  end

  always_comb begin
    if (BOOT_SWAP && in_range(phys, SWAP_OFFSET, SWAP_OFFSET + SECID_LAST)) begin
      farea = flash_area(phys - SWAP_OFFSET); // [RL9]
    end else begin
      farea = flash_area(phys);
    end
  end

  assign ram_we   = REQ && WRITE && (region == MMDEC_RAM || region == MMDEC_GPR);
  assign ram_addr = 13'(ADDR - RAM_BASE);

  mmdec_ram #(.DEPTH(RAM_BYTES), .AW(13)) u_ram (
    .clk   (CLOCK),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (WDATA),
    .rdata (ram_rdata)
  );

  // flash is read by address, byte wide; a vector's halves come at even then odd
  assign FLASH_ADDR = phys[16:0]; // [RL4] [RL3]
  assign FLASH_RD   = REQ && !WRITE && !prohibited &&
                      (region == MMDEC_FLASH || region == MMDEC_MIRROR);
  assign SFR_SEL    = REQ && region == MMDEC_SFR;
  assign EXT_SEL    = REQ && region == MMDEC_EXT;

  always_comb begin
    next_state      = state;
    next_state.pend = REQ && !WRITE;
    next_state.bad  = REQ && prohibited;
    // read answer stands two edges after the request
    next_state.valid = state.pend; // [RL22]
    if (REQ) begin
      next_state.reg_q = region;
    end
    if (REQ && WRITE && region == MMDEC_MSC) begin
      if (BIT_OP) begin
        if (BIT_SEL == 3'(MSC_SEL_BIT)) begin
          next_state.msc[MSC_SEL_BIT] = WDATA[0]; // [RL14]
        end
      end else begin
        next_state.msc[MSC_SEL_BIT] = WDATA[MSC_SEL_BIT]; // [RL14]
      end
    end
    // flash and mirror data are sampled the cycle after the address
    next_state.rdat = UNDEF_DATA; // [RL22]
    if (state.pend && !state.bad) begin
      case (state.reg_q)
        MMDEC_FLASH, MMDEC_MIRROR: next_state.rdat = FLASH_RDATA; // [RL11]
        MMDEC_RAM, MMDEC_GPR:      next_state.rdat = ram_rdata;
        MMDEC_MSC:                 next_state.rdat = state.msc; // [RL15]
        default:                   next_state.rdat = UNDEF_DATA;
      endcase
    end
    if (RESET) begin
      next_state.msc   = MSC_RESET; // [RL14]
      next_state.pend  = 1'b0;
      next_state.reg_q = MMDEC_NONE;
      next_state.bad   = 1'b0;
      next_state.valid = 1'b0;
      next_state.rdat  = UNDEF_DATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    state <= next_state;
  end

  assign VALID         = state.valid;
  assign RDATA         = state.rdat;
  assign ACC_ERROR     = state.bad;
  assign REGION        = state.reg_q;
  assign FLASH_AREA    = farea;
  assign MIRROR_SELECT = state.msc[MSC_SEL_BIT];

  a_mirror_maps_low: assert property (@(posedge CLOCK) disable iff (RESET) // [RL11]
    (REQ && !WRITE && !FETCH && ADDR >= 20'hF0800 && ADDR < RAM_BASE)
      |-> (FLASH_RD && FLASH_ADDR == {1'b0, ADDR[15:0]}))
    else $error("mirror read not mapped to low flash");

  a_mirror_no_write: assert property (@(posedge CLOCK) disable iff (RESET) // [RL13]
    (REQ && WRITE && region == MMDEC_MIRROR) |=> ACC_ERROR)
    else $error("mirror write not flagged");

  a_mirror_no_fetch: assert property (@(posedge CLOCK) disable iff (RESET) // [RL13]
    (REQ && FETCH && ADDR > EXT_LAST && ADDR < RAM_BASE) |-> !FLASH_RD)
    else $error("mirror fetch reached flash");

  a_ram_wins_mirror: assert property (@(posedge CLOCK) disable iff (RESET) // [RL12]
    (REQ && ADDR >= RAM_BASE && ADDR <= RAM_LAST) |-> !FLASH_RD)
    else $error("flash read inside ram");

  a_ext_window: assert property (@(posedge CLOCK) disable iff (RESET) // [RL20]
    (REQ && ADDR >= MIRROR_BASE && ADDR <= EXT_LAST) |-> (EXT_SEL && !FLASH_RD))
    else $error("extended window not selected");

  a_sfr_window: assert property (@(posedge CLOCK) disable iff (RESET) // [RL19]
    (REQ && ADDR >= SFR_BASE && ADDR != MSC_ADDR) |-> SFR_SEL)
    else $error("peripheral window not selected");

  a_flash_range: assert property (@(posedge CLOCK) disable iff (RESET) // [RL1]
    (REQ && !WRITE && ADDR <= FLASH_LAST) |-> (FLASH_RD && FLASH_ADDR == ADDR[16:0]))
    else $error("flash address not passed through");

  a_gpr_no_fetch: assert property (@(posedge CLOCK) disable iff (RESET) // [RL18]
    (REQ && FETCH && ADDR >= GPR_BASE && ADDR < SFR_BASE) |=> ACC_ERROR)
    else $error("register bank fetch not flagged");

  a_unmapped_error: assert property (@(posedge CLOCK) disable iff (RESET) // [RL22]
    (REQ && ADDR > FLASH_LAST && ADDR < MIRROR_BASE) |=> ACC_ERROR)
    else $error("unmapped access not flagged");

  a_undef_read: assert property (@(posedge CLOCK) disable iff (RESET) // [RL22]
    (REQ && !WRITE && ADDR > FLASH_LAST && ADDR < MIRROR_BASE)
      |-> ##2 (RDATA == UNDEF_DATA))
    else $error("unmapped read data not undefined");

  sequence s_msc_write;
    REQ && WRITE && !BIT_OP && ADDR == MSC_ADDR;
  endsequence
  sequence s_msc_read;
    REQ && !WRITE && ADDR == MSC_ADDR;
  endsequence
  a_msc_readback: assert property (@(posedge CLOCK) disable iff (RESET) // [RL14]
    (s_msc_write ##1 s_msc_read) |-> ##2 (RDATA == {7'h00, $past(WDATA[0], 3)}))
    else $error("mirror control readback wrong");

  a_msc_reset: assert property (@(posedge CLOCK) // [RL14]
    $fell(RESET) |-> (MIRROR_SELECT == 1'b0))
    else $error("mirror control not cleared by reset");

  a_vector_area: assert property (@(posedge CLOCK) disable iff (RESET) // [RL2]
    (!BOOT_SWAP && ADDR <= VEC_LAST) |-> (FLASH_AREA == MMDEC_FA_VEC))
    else $error("vector area not flagged");

  a_short_table_call_area: assert property (@(posedge CLOCK) disable iff (RESET) // [RL7]
    (ADDR >= SHORT_TABLE_CALL_BASE && ADDR <= SHORT_TABLE_CALL_LAST) |-> (FLASH_AREA == MMDEC_FA_SHORT_TABLE_CALL))
    else $error("table call area not flagged");

  a_read_latency: assert property (@(posedge CLOCK) disable iff (RESET) // [RL22]
    (REQ && !WRITE) |-> ##2 VALID)
    else $error("read answer not two cycles later");

endmodule : mmdec_top
